/* File: rtl/cct_regs.vh */
// Register indices, field positions, reset values and timing counts of the timer core.
`ifndef CCT_REGS_VH
`define CCT_REGS_VH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define IDX_CHAN_MODE     6'h00
`define IDX_FORCE         6'h01
`define IDX_CH7_MASK      6'h02
`define IDX_CH7_DATA      6'h03
`define IDX_COUNT_HI      6'h04
`define IDX_COUNT_LO      6'h05
`define IDX_SYS_CTRL      6'h06
`define IDX_OUT_CTRL      6'h08
`define IDX_EDGE_CTRL     6'h0a
`define IDX_SYS_CTRL2     6'h0d
`define IDX_CHAN_FLAGS    6'h0e
`define IDX_OVF_FLAG      6'h0f
`define IDX_CHAN_BASE     6'h18
`define IDX_PA_CTRL       6'h20
`define IDX_PA_FLAGS      6'h21
`define IDX_PA_COUNT_HI   6'h22
`define IDX_PA_COUNT_LO   6'h23

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SC_RUN_EN         7
`define SC_WAIT_STOP      6
`define SC_FREEZE_STOP    5
`define PA_EN             6
`define PA_MOD            5
`define PA_EDGE           4
`define PAF_OVF           1
`define PAF_EDGE          0

// ----------------------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------------------
`define RST_BYTE          8'h00
`define RST_WORD          16'h0000
`define RST_NIB           4'h0
`define GATE_DIV_BITS     6

`endif

/* File: rtl/cct_channel.v */
// One input-capture / output-compare channel of the timer core.
`timescale 1ns/1ps
`include "cct_regs.vh"

module cct_channel
(
    input  wire        clk,
    input  wire        rst,
    input  wire        pin_lvl,
    input  wire        active,
    input  wire        ios,
    input  wire [1:0]  edge_sel,
    input  wire [1:0]  out_mode,
    input  wire [15:0] count,
    input  wire        tick,
    input  wire        wr_en,
    input  wire [15:0] wr_data,
    input  wire        force_hit,
    input  wire        oc7_take,
    input  wire        oc7_val,
    output wire        flag_set,
    output wire [15:0] value,
    output wire        pin_out
);

    reg         prev_q;
    reg  [15:0] value_q;
    reg         out_q;
    wire        rise     = pin_lvl & ~prev_q;
    wire        fall     = ~pin_lvl & prev_q;
    wire        edge_hit = active & ~ios & ((edge_sel[0] & rise) | (edge_sel[1] & fall)); // R3
    wire        match    = ios & tick & (count == value_q); // R4

    assign flag_set = edge_hit | match;
    assign value    = value_q;
    assign pin_out  = out_q;

    always @(posedge clk)
    begin
        if (rst)
        begin
            prev_q  <= 1'b0;
            value_q <= `RST_WORD;
            out_q   <= 1'b0;
        end
        else
        begin
            prev_q <= pin_lvl;
            // Capture has priority; writes only land in compare mode.
            if (edge_hit)
                value_q <= count; // R3
            else if (wr_en && ios)
                value_q <= wr_data;
            if (oc7_take)
                out_q <= oc7_val; // R4
            else if (ios && active && (match || force_hit))
            begin
                case (out_mode)
                    2'b01:   out_q <= ~out_q; // R4
                    2'b10:   out_q <= 1'b0;
                    2'b11:   out_q <= 1'b1;
                    default: out_q <= out_q;
                endcase
            end
        end
    end

endmodule // cct_channel

/* File: rtl/capture_compare_timer_core.v */
// Top of the timer core: counter, prescaler, four channels, pulse accumulator, bus slave.
`timescale 1ns/1ps
`include "cct_regs.vh"

// Contract
// R1: 16-bit counter clocked by seven-stage prescaler.
// R2: Four channels 7..4, capture or compare each.
// R3: Capture latches count on selected pin edge.
// R4: Compare drives pin activity on match.
// R5: Pulse accumulator: event counter or gated timer.
// R6: Event mode counts the channel 7 pin.
// R7: Channel 7 pin selectable as accumulator input.
// R8: Software reads words whole, not bytewise.
// R9: Freeze halts counter only if freeze-stop set.
// R10: Wait halts counters only if wait-stop set.
// R11: Normal mode counts only while run-enable set.
// R12: Stop mode: no counting, capture or compare.
// R13: Counter writable only in test mode.
// R14: Reserved locations read zero, ignore writes.
// R15: Counter increments per tick, wraps to zero.
module capture_compare_timer_core
(
    input  wire        CLK_SYS,
    input  wire        SYS_RST,
    input  wire [7:0]  AVS_ADDRESS,
    input  wire        AVS_READ,
    input  wire        AVS_WRITE,
    input  wire [3:0]  AVS_BYTEENABLE,
    input  wire [31:0] AVS_WRITEDATA,
    output wire [31:0] AVS_READDATA,
    output wire        AVS_WAITREQUEST,
    input  wire        STOP_MODE,
    input  wire        WAIT_MODE,
    input  wire        FREEZE_MODE,
    input  wire        TEST_MODE,
    input  wire [3:0]  CHANNEL_PIN_IN,
    output wire [3:0]  CHANNEL_PIN_OUT,
    output wire [3:0]  CHANNEL_PIN_OE
);

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    // Byte-lane merge of a 16-bit register with a bus write.
    function [15:0] merge16;
        input [15:0] old;
        input [15:0] data;
        input [1:0]  be;
        begin
            merge16 = {be[1] ? data[15:8] : old[15:8], be[0] ? data[7:0] : old[7:0]};
        end
    endfunction

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    reg  [3:0]  ios_q;
    reg  [3:0]  ch7_mask_q;
    reg  [3:0]  ch7_data_q;
    reg  [7:0]  out_ctrl_q;
    reg  [7:0]  edge_ctrl_q;
    reg         run_en_q;
    reg         wait_stop_q;
    reg         freeze_stop_q;
    reg  [2:0]  presc_sel_q;
    reg  [3:0]  chan_flag_q;
    reg         ovf_flag_q;
    reg         pa_en_q;
    reg         pa_mod_q;
    reg         pa_edge_q;
    reg         pa_ovf_q;
    reg         pa_if_q;
    reg  [15:0] pa_count_q;
    reg  [15:0] count_q;
    reg  [6:0]  presc_q;
    reg  [`GATE_DIV_BITS-1:0] gate_div_q;
    reg  [3:0]  sync1_q;
    reg  [3:0]  sync2_q;
    reg         pa_prev_q;
    reg  [3:0]  oe_q;
    reg         wait_q;
    reg  [31:0] rdata_q;
    reg  [31:0] rdata_d;

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    wire [5:0]  idx     = AVS_ADDRESS[7:2];
    wire        req     = AVS_READ | AVS_WRITE;
    wire        wr_fire = AVS_WRITE & ~wait_q;
    wire        be0     = AVS_BYTEENABLE[0];
    wire [7:0]  wbyte   = AVS_WRITEDATA[7:0];
    wire [15:0] wword   = AVS_WRITEDATA[15:0];

    // ------------------------------------------------------------------------
    // Run conditions
    // ------------------------------------------------------------------------
    wire        active  = ~STOP_MODE; // R12
    wire        halt    = (WAIT_MODE & wait_stop_q) | (FREEZE_MODE & freeze_stop_q); // R9 R10
    wire        run     = active & run_en_q & ~halt; // R11 R12
    wire        pa_run  = active & ~halt; // R10
    wire [6:0]  presc_mask = ~(7'h7f << presc_sel_q);
    wire        tick    = run & ((presc_q & presc_mask) == presc_mask); // R1

    // ------------------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------------------
    wire [3:0]  ch_set;
    wire [15:0] ch_val [0:3];
    wire [3:0]  ch_out;
    wire        oc7_hit = ch_set[3] & ios_q[3] & active;

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : chan
            wire wr_this = wr_fire & (idx == `IDX_CHAN_BASE + 2 * g);
            cct_channel u_chan
            (
                .clk      (CLK_SYS),
                .rst      (SYS_RST),
                .pin_lvl  (sync2_q[g]),
                .active   (active),
                .ios      (ios_q[g]),
                .edge_sel (edge_ctrl_q[2*g+1:2*g]),
                .out_mode (out_ctrl_q[2*g+1:2*g]),
                .count    (count_q),
                .tick     (tick),
                .wr_en    (wr_this),
                .wr_data  (merge16(ch_val[g], wword, AVS_BYTEENABLE[1:0])),
                .force_hit(wr_fire & (idx == `IDX_FORCE) & be0 & wbyte[4+g]),
                .oc7_take (oc7_hit & ch7_mask_q[g] & ios_q[g]),
                .oc7_val  (ch7_data_q[g]),
                .flag_set (ch_set[g]),
                .value    (ch_val[g]),
                .pin_out  (ch_out[g])
            ); // R2
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Pulse accumulator
    // ------------------------------------------------------------------------
    // In event mode the channel 7 pin is an input only, so its driver is released.
    wire        pa_lvl    = sync2_q[3]; // R6 R7
    wire        pa_edge   = pa_edge_q ? (pa_lvl & ~pa_prev_q) : (~pa_lvl & pa_prev_q);
    wire        gate_on   = pa_edge_q ? ~pa_lvl : pa_lvl;
    wire        pa_inc    = pa_en_q & pa_run &
                            (pa_mod_q ? (gate_on & (&gate_div_q)) : pa_edge); // R5 R6
    wire        pa_evt    = pa_en_q & pa_run & pa_edge; // R5
    wire        pa_wr     = wr_fire & (idx == `IDX_PA_COUNT_HI);

    // ------------------------------------------------------------------------
    // Sequential logic
    // ------------------------------------------------------------------------
    always @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            ios_q         <= `RST_NIB;
            ch7_mask_q    <= `RST_NIB;
            ch7_data_q    <= `RST_NIB;
            out_ctrl_q    <= `RST_BYTE;
            edge_ctrl_q   <= `RST_BYTE;
            run_en_q      <= 1'b0;
            wait_stop_q   <= 1'b0;
            freeze_stop_q <= 1'b0;
            presc_sel_q   <= 3'h0;
            chan_flag_q   <= `RST_NIB;
            ovf_flag_q    <= 1'b0;
            pa_en_q       <= 1'b0;
            pa_mod_q      <= 1'b0;
            pa_edge_q     <= 1'b0;
            pa_ovf_q      <= 1'b0;
            pa_if_q       <= 1'b0;
            pa_count_q    <= `RST_WORD;
            count_q       <= `RST_WORD;
            presc_q       <= 7'h00;
            gate_div_q    <= {`GATE_DIV_BITS{1'b0}};
            sync1_q       <= `RST_NIB;
            sync2_q       <= `RST_NIB;
            pa_prev_q     <= 1'b0;
            oe_q          <= `RST_NIB;
            wait_q        <= 1'b1;
            rdata_q       <= 32'h00000000;
        end
        else
        begin
            sync1_q   <= CHANNEL_PIN_IN;
            sync2_q   <= sync1_q;
            pa_prev_q <= sync2_q[3];
            oe_q      <= ios_q & {~(pa_en_q & ~pa_mod_q), 3'h7}; // R7

            // One wait state: data is latched as the request is seen.
            if (req && wait_q)
            begin
                wait_q  <= 1'b0;
                rdata_q <= AVS_READ ? rdata_d : 32'h00000000;
            end
            else
                wait_q <= 1'b1;

            if (run)
                presc_q <= presc_q + 7'h01; // R1
            if (pa_run)
                gate_div_q <= gate_div_q + {{(`GATE_DIV_BITS-1){1'b0}}, 1'b1};

            if (wr_fire && TEST_MODE && idx == `IDX_COUNT_HI)
                count_q <= merge16(count_q, wword, AVS_BYTEENABLE[1:0]); // R13
            else if (tick)
                count_q <= count_q + 16'h0001; // R15

            if (pa_wr)
                pa_count_q <= merge16(pa_count_q, wword, AVS_BYTEENABLE[1:0]);
            else if (pa_inc)
                pa_count_q <= pa_count_q + 16'h0001; // R5

            if (wr_fire && be0)
            begin
                case (idx)
                    `IDX_CHAN_MODE:  ios_q       <= wbyte[7:4];
                    `IDX_CH7_MASK:   ch7_mask_q  <= wbyte[7:4];
                    `IDX_CH7_DATA:   ch7_data_q  <= wbyte[7:4];
                    `IDX_OUT_CTRL:   out_ctrl_q  <= wbyte;
                    `IDX_EDGE_CTRL:  edge_ctrl_q <= wbyte;
                    `IDX_SYS_CTRL2:  presc_sel_q <= wbyte[2:0];
                    `IDX_SYS_CTRL:
                    begin
                        run_en_q      <= wbyte[`SC_RUN_EN];
                        wait_stop_q   <= wbyte[`SC_WAIT_STOP];
                        freeze_stop_q <= wbyte[`SC_FREEZE_STOP];
                    end
                    `IDX_PA_CTRL:
                    begin
                        pa_en_q   <= wbyte[`PA_EN];
                        pa_mod_q  <= wbyte[`PA_MOD];
                        pa_edge_q <= wbyte[`PA_EDGE];
                    end
                    default: ;
                endcase
            end

            // Flags clear on a written one, but a same-cycle event still sets them.
            chan_flag_q <= (chan_flag_q &
                            ~((wr_fire && be0 && idx == `IDX_CHAN_FLAGS) ? wbyte[7:4] : 4'h0))
                           | (ch_set & {4{active}});
            ovf_flag_q  <= (ovf_flag_q & ~(wr_fire && be0 && idx == `IDX_OVF_FLAG && wbyte[7]))
                           | (tick & (&count_q)); // R15
            pa_if_q     <= (pa_if_q & ~(wr_fire && be0 && idx == `IDX_PA_FLAGS && wbyte[0]))
                           | pa_evt;
            pa_ovf_q    <= (pa_ovf_q & ~(wr_fire && be0 && idx == `IDX_PA_FLAGS && wbyte[1]))
                           | (pa_inc & ~pa_wr & (&pa_count_q));
        end
    end

    // ------------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------------
    always @*
    begin
        rdata_d = 32'h00000000; // R14
        case (idx)
            `IDX_CHAN_MODE:   rdata_d[7:0] = {ios_q, 4'h0};
            `IDX_CH7_MASK:    rdata_d[7:0] = {ch7_mask_q, 4'h0};
            `IDX_CH7_DATA:    rdata_d[7:0] = {ch7_data_q, 4'h0};
            `IDX_COUNT_HI:    rdata_d[15:0] = count_q; // R8
            `IDX_COUNT_LO:    rdata_d[7:0] = count_q[7:0];
            `IDX_SYS_CTRL:    rdata_d[7:0] = {run_en_q, wait_stop_q, freeze_stop_q, 5'h00};
            `IDX_OUT_CTRL:    rdata_d[7:0] = out_ctrl_q;
            `IDX_EDGE_CTRL:   rdata_d[7:0] = edge_ctrl_q;
            `IDX_SYS_CTRL2:   rdata_d[7:0] = {5'h00, presc_sel_q};
            `IDX_CHAN_FLAGS:  rdata_d[7:0] = {chan_flag_q, 4'h0};
            `IDX_OVF_FLAG:    rdata_d[7:0] = {ovf_flag_q, 7'h00};
            `IDX_CHAN_BASE:           rdata_d[15:0] = ch_val[0]; // R8
            `IDX_CHAN_BASE + 6'h01:   rdata_d[7:0]  = ch_val[0][7:0];
            `IDX_CHAN_BASE + 6'h02:   rdata_d[15:0] = ch_val[1];
            `IDX_CHAN_BASE + 6'h03:   rdata_d[7:0]  = ch_val[1][7:0];
            `IDX_CHAN_BASE + 6'h04:   rdata_d[15:0] = ch_val[2];
            `IDX_CHAN_BASE + 6'h05:   rdata_d[7:0]  = ch_val[2][7:0];
            `IDX_CHAN_BASE + 6'h06:   rdata_d[15:0] = ch_val[3];
            `IDX_CHAN_BASE + 6'h07:   rdata_d[7:0]  = ch_val[3][7:0];
            `IDX_PA_CTRL:     rdata_d[7:0] = {1'b0, pa_en_q, pa_mod_q, pa_edge_q, 4'h0};
            `IDX_PA_FLAGS:    rdata_d[7:0] = {6'h00, pa_ovf_q, pa_if_q};
            `IDX_PA_COUNT_HI: rdata_d[15:0] = pa_count_q;
            `IDX_PA_COUNT_LO: rdata_d[7:0] = pa_count_q[7:0];
            default:          rdata_d = 32'h00000000; // R14
        endcase
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    // Pin data comes from each channel's own flip-flop; the enable is registered here.
    assign AVS_READDATA    = rdata_q;
    assign AVS_WAITREQUEST = wait_q;
    assign CHANNEL_PIN_OUT = ch_out;
    assign CHANNEL_PIN_OE  = oe_q; // R2

endmodule // capture_compare_timer_core

/* File: sim/cct_chk.sv */
// Checker of the timer core: bus handshake, zero reads, reset state and stop-mode pins.
`timescale 1ns/1ps

module cct_chk
(
    input wire        CLK_SYS,
    input wire        SYS_RST,
    input wire [7:0]  AVS_ADDRESS,
    input wire        AVS_READ,
    input wire        AVS_WRITE,
    input wire [3:0]  AVS_BYTEENABLE,
    input wire [31:0] AVS_WRITEDATA,
    input wire [31:0] AVS_READDATA,
    input wire        AVS_WAITREQUEST,
    input wire        STOP_MODE,
    input wire        WAIT_MODE,
    input wire        FREEZE_MODE,
    input wire        TEST_MODE,
    input wire [3:0]  CHANNEL_PIN_IN,
    input wire [3:0]  CHANNEL_PIN_OUT,
    input wire [3:0]  CHANNEL_PIN_OE
);
    wire [5:0] idx  = AVS_ADDRESS[7:2];
    wire       take = (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
    // Everything from 0x24 up reads zero, the unimplemented test register included.
    wire       rsv  = idx == 6'h09 || idx == 6'h0b || idx[5:3] == 3'b010 || idx >= 6'h24;

    default clocking dc @(posedge CLK_SYS);
    endclocking
    default disable iff (SYS_RST);

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    AST_RESET_STATE: assert property (disable iff (1'b0) SYS_RST |=> AVS_WAITREQUEST
        && AVS_READDATA == 32'h0 && CHANNEL_PIN_OUT == 4'h0 && CHANNEL_PIN_OE == 4'h0)
        else $error("Outputs not cleared by reset.");
    AST_ONE_WAIT: assert property (take |=> !AVS_WAITREQUEST)
        else $error("Request not answered after one wait state.");
    AST_WAIT_PULSE: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("Waitrequest low for more than one cycle.");
    AST_NO_SPURIOUS: assert property (!AVS_READ && !AVS_WRITE && AVS_WAITREQUEST
        |=> AVS_WAITREQUEST)
        else $error("Answer without a request.");
    AST_RSV_ZERO: assert property (AVS_READ && take && rsv |=> AVS_READDATA == 32'h0)
        else $error("Reserved place read nonzero.");
    AST_FORCE_ZERO: assert property (AVS_READ && take && idx == 6'h01 |=> AVS_READDATA == 32'h0)
        else $error("Force register read nonzero.");
    AST_UPPER_ZERO: assert property (!AVS_WAITREQUEST |-> AVS_READDATA[31:16] == 16'h0)
        else $error("Upper read lanes not zero.");
    AST_DATA_HOLD: assert property (!take |=> $stable(AVS_READDATA))
        else $error("Read data changed without a request.");
    AST_WRITE_ZERO: assert property (AVS_WRITE && take |=> AVS_READDATA == 32'h0)
        else $error("Read data not zero after a write.");
    AST_STOP_PINS: assert property (STOP_MODE && $past(STOP_MODE)
        |-> $stable(CHANNEL_PIN_OUT) && $stable(CHANNEL_PIN_OE))
        else $error("Pin activity in stop mode.");

    CV_READ: cover property (AVS_READ && !AVS_WAITREQUEST);
    CV_WRITE: cover property (AVS_WRITE && !AVS_WAITREQUEST);
    CV_STOP: cover property (STOP_MODE ##1 STOP_MODE);
    CV_PIN: cover property ($rose(CHANNEL_PIN_OUT[1]));
endmodule // cct_chk

bind capture_compare_timer_core cct_chk u_chk
(
    .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .STOP_MODE(STOP_MODE),
    .WAIT_MODE(WAIT_MODE), .FREEZE_MODE(FREEZE_MODE), .TEST_MODE(TEST_MODE),
    .CHANNEL_PIN_IN(CHANNEL_PIN_IN), .CHANNEL_PIN_OUT(CHANNEL_PIN_OUT),
    .CHANNEL_PIN_OE(CHANNEL_PIN_OE)
);

/* File: sim/capture_compare_timer_core_test.sv */
// Register-level regression of the timer core: counter modes, capture, compare, accumulator.
`timescale 1ns/1ps
`include "cct_regs.vh"

module capture_compare_timer_core_test;
    // Force and reserved places, all read as zero.
    localparam [29:0] ZIDX = {6'h01, 6'h09, 6'h10, 6'h2e, 6'h3f};
    // Mode table, entry 0 at the right: mode select, control byte, halted.
    localparam [13:0] MSEL = {2'd0, 2'd0, 2'd3, 2'd2, 2'd2, 2'd1, 2'd1};
    localparam [55:0] MCTL = {8'h80, 8'h00, 8'h80, 8'ha0, 8'h80, 8'hc0, 8'h80};
    localparam [6:0]  MHLT = 7'b0111010;
    localparam [5:0]  CH5  = `IDX_CHAN_BASE + 6'h02;
    reg         clk = 1'b0, rst = 1'b1, rde = 1'b0, wre = 1'b0;
    reg         stop_m = 1'b0, wait_m = 1'b0, frz_m = 1'b0, test_m = 1'b0;
    reg  [7:0]  adr = 8'h00;
    reg  [3:0]  be = 4'h0, pin_in = 4'h0;
    reg  [31:0] wdat = 32'h0, d;
    reg  [15:0] a;
    wire [31:0] rdat;
    wire        wreq;
    wire [3:0]  pin_out, pin_oe;
    integer     errors = 0, comparisons = 0, cycles = 0, i;

    always #50 clk = ~clk;

    capture_compare_timer_core DUT
    (
        .CLK_SYS(clk), .SYS_RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rde), .AVS_WRITE(wre),
        .AVS_BYTEENABLE(be), .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
        .STOP_MODE(stop_m), .WAIT_MODE(wait_m), .FREEZE_MODE(frz_m), .TEST_MODE(test_m),
        .CHANNEL_PIN_IN(pin_in), .CHANNEL_PIN_OUT(pin_out), .CHANNEL_PIN_OE(pin_oe)
    );

    // ------------------------------------------------------------------------
    // Bus and report tasks
    // ------------------------------------------------------------------------
    // The leading edge keeps a release and the next request out of one time step.
    task bus(input w, input [5:0] x, input [31:0] v, input [3:0] b);
        begin
            @(posedge clk);
            adr  <= {x, 2'b00};
            wdat <= v;
            be   <= b;
            wre  <= w;
            rde  <= !w;
            do @(posedge clk); while (wreq !== 1'b0);
            d = rdat;
            wre  <= 1'b0;
            rde  <= 1'b0;
        end
    endtask

    task chk(input [31:0] s, input [31:0] e);
        begin
            comparisons = comparisons + 1;
            if (s !== e)
            begin
                errors = errors + 1;
                $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
            end
        end
    endtask

    task rc(input [5:0] x, input [31:0] e);
        begin
            bus(1'b0, x, 32'h0, 4'hf);
            chk(d, e);
        end
    endtask

    task wrap_up;
        begin
            $display("errors=%0d comparisons=%0d", errors, comparisons);
            if (errors == 0 && comparisons > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask

    always @(posedge clk)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            errors = errors + 1;
            wrap_up;
        end
    end

    // ------------------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rc(`IDX_SYS_CTRL, 32'h0);
        for (i = 0; i < 5; i = i + 1)
        begin
            bus(1'b1, ZIDX[i*6+:6], 32'hffff, 4'hf);
            rc(ZIDX[i*6+:6], 32'h0);
        end
        bus(1'b1, `IDX_COUNT_HI, 32'h1234, 4'h3);
        rc(`IDX_COUNT_HI, 32'h0);
        test_m <= 1'b1;
        bus(1'b1, `IDX_COUNT_HI, 32'h1234, 4'h3);
        bus(1'b1, `IDX_COUNT_HI, 32'h56ab, 4'h1);
        rc(`IDX_COUNT_HI, 32'h12ab);
        // Samples lie 1283 cycles apart, so ten or eleven ticks of 128 fall between them.
        bus(1'b1, `IDX_SYS_CTRL2, 32'h7, 4'h1);
        bus(1'b1, `IDX_SYS_CTRL, 32'h80, 4'h1);
        bus(1'b0, `IDX_COUNT_HI, 32'h0, 4'hf);
        a = d[15:0];
        repeat (1280) @(posedge clk);
        bus(1'b0, `IDX_COUNT_HI, 32'h0, 4'hf);
        a = d[15:0] - a;
        chk(a >= 16'd10 && a <= 16'd11, 32'h1);
        bus(1'b1, `IDX_SYS_CTRL2, 32'h0, 4'h1);
        bus(1'b1, `IDX_COUNT_HI, 32'hfffe, 4'h3);
        repeat (4) @(posedge clk);
        bus(1'b0, `IDX_COUNT_HI, 32'h0, 4'hf);
        chk(d < 32'h10, 32'h1);
        rc(`IDX_OVF_FLAG, 32'h80);
        for (i = 0; i < 7; i = i + 1)
        begin
            wait_m <= (MSEL[i*2+:2] == 2'd1);
            frz_m  <= (MSEL[i*2+:2] == 2'd2);
            stop_m <= (MSEL[i*2+:2] == 2'd3);
            bus(1'b1, `IDX_SYS_CTRL, MCTL[i*8+:8], 4'h1);
            bus(1'b1, `IDX_COUNT_HI, 32'h0200, 4'h3);
            repeat (20) @(posedge clk);
            bus(1'b0, `IDX_COUNT_HI, 32'h0, 4'hf);
            chk(MHLT[i] ? d == 32'h0200 : d > 32'h0200, 32'h1);
        end
        bus(1'b1, `IDX_SYS_CTRL, 32'h0, 4'h1);
        bus(1'b1, `IDX_EDGE_CTRL, 32'h01, 4'h1);
        bus(1'b1, `IDX_COUNT_HI, 32'h0abc, 4'h3);
        pin_in[0] <= 1'b1;
        repeat (6) @(posedge clk);
        rc(`IDX_CHAN_BASE, 32'h0abc);
        rc(`IDX_CHAN_FLAGS, 32'h10);
        bus(1'b1, `IDX_CHAN_FLAGS, 32'h10, 4'h1);
        bus(1'b1, `IDX_COUNT_HI, 32'h0def, 4'h3);
        pin_in[0] <= 1'b0;
        repeat (6) @(posedge clk);
        rc(`IDX_CHAN_BASE, 32'h0abc);
        rc(`IDX_CHAN_FLAGS, 32'h0);
        bus(1'b1, CH5, 32'h0030, 4'h3);
        rc(CH5, 32'h0);
        bus(1'b1, `IDX_CHAN_MODE, 32'h20, 4'h1);
        bus(1'b1, `IDX_OUT_CTRL, 32'h0c, 4'h1);
        bus(1'b1, CH5, 32'h0030, 4'h3);
        bus(1'b1, `IDX_COUNT_HI, 32'h0, 4'h3);
        @(negedge clk);
        chk(pin_oe[1], 1'b1);
        chk(pin_out[1], 1'b0);
        bus(1'b1, `IDX_SYS_CTRL, 32'h80, 4'h1);
        repeat (60) @(negedge clk);
        chk(pin_out[1], 1'b1);
        rc(`IDX_CHAN_FLAGS, 32'h20);
        bus(1'b1, `IDX_OUT_CTRL, 32'h08, 4'h1);
        bus(1'b1, `IDX_FORCE, 32'h20, 4'h1);
        @(negedge clk);
        chk(pin_out[1], 1'b0);
        bus(1'b1, `IDX_CHAN_MODE, 32'ha0, 4'h1);
        repeat (3) @(negedge clk);
        chk(pin_oe[3], 1'b1);
        bus(1'b1, `IDX_PA_CTRL, 32'h50, 4'h1);
        repeat (3) @(negedge clk);
        chk(pin_oe[3], 1'b0);
        for (i = 0; i < 3; i = i + 1)
        begin
            @(posedge clk);
            pin_in[3] <= 1'b1;
            repeat (4) @(posedge clk);
            pin_in[3] <= 1'b0;
            repeat (4) @(posedge clk);
        end
        rc(`IDX_PA_COUNT_HI, 32'h3);
        rc(`IDX_PA_FLAGS, 32'h1);
        // Gated mode: the gate stays open for 200 cycles, so three or four 64-cycle steps.
        bus(1'b1, `IDX_PA_FLAGS, 32'h1, 4'h1);
        bus(1'b1, `IDX_PA_COUNT_HI, 32'h0, 4'h3);
        bus(1'b1, `IDX_PA_CTRL, 32'h60, 4'h1);
        pin_in[3] <= 1'b1;
        repeat (200) @(posedge clk);
        pin_in[3] <= 1'b0;
        repeat (4) @(posedge clk);
        bus(1'b0, `IDX_PA_COUNT_HI, 32'h0, 4'hf);
        chk(d >= 32'h3 && d <= 32'h4, 32'h1);
        rc(`IDX_PA_FLAGS, 32'h1);
        wrap_up;
    end
endmodule // capture_compare_timer_core_test
